// ### rtl/core_sfr.sv
// The placing of the registers and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/10ps
module core_sfr
	import core_sfr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Watchdog-reset marker: last reset came from watchdog while idle
	input  wire logic        wdt_idle_reset,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_awaddr,
	input  wire logic        s_awvalid,
	output logic             s_awready,
	input  wire logic [31:0] s_wdata,
	input  wire logic [3:0]  s_wstrb,
	input  wire logic        s_wvalid,
	output logic             s_wready,
	output logic [1:0]       s_bresp,
	output logic             s_bvalid,
	input  wire logic        s_bready,
	input  wire logic [7:0]  s_araddr,
	input  wire logic        s_arvalid,
	output logic             s_arready,
	output logic [31:0]      s_rdata,
	output logic [1:0]       s_rresp,
	output logic             s_rvalid,
	input  wire logic        s_rready,
	// Core events
	input  wire alu_ev_t     alu_ev,
	input  wire sys_ev_t     sys_ev,
	input  wire logic        acc_load,
	input  wire logic [7:0]  acc_in,
	// Program counter and table read
	input  wire logic [10:0] pc_in,
	input  wire logic        tbl_rd,
	input  wire logic [15:0] prog_word,
	output logic [10:0]      pc_jump,
	output logic             pc_jump_vld,
	output logic             dummy_cycle,
	output logic [15:0]      tbl_fetch_addr,
	output logic [7:0]       tbl_low_byte,
	output logic             tbl_low_vld,
	// Data memory access resolution
	input  wire logic        dm_via_any_ptr,
	input  wire logic [7:0]  dm_addr,
	output logic [2:0]       dm_bank,
	output logic             dm_bank_ok,
	output logic [7:0]       dm_ptr_addr,
	// Clock selection and status view
	output logic [2:0]       sys_clk_sel,
	output logic             sys_clk_slow,
	output logic [7:0]       status_out
);

	logic [2:0]  bank_q;
	logic [2:0]  bank_keep_q;
	logic [3:0]  arith_q;
	logic        halted_q;
	logic        expired_q;
	logic [7:0]  status_q;
	logic [7:0]  tbl_lo_q;
	logic [7:0]  tbl_hi_q;
	logic [7:0]  tbl_latch_q;
	logic [7:0]  clk_ctrl_q;
	logic [7:0]  acc_q;
	logic [7:0]  mptr_q;
	logic [7:0]  aw_addr_q;
	logic        aw_have_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        w_have_q;
	logic        wr_fire;
	logic        wr_lane0;
	logic [7:0]  wr_byte;
	logic [2:0]  bank_res;
	logic        bank_res_ok;
	logic        boot_q;
	arith_flags_t alu_f;

	// Write fires once both address and data are held and no resp pending
	assign wr_fire  = aw_have_q && w_have_q && !s_bvalid;
	assign wr_lane0 = w_strb_q[0];
	assign wr_byte  = w_data_q[7:0];

	// Marks the first edge after release, when the reset cause is valid
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			boot_q <= 1'b1;
		end else begin
			boot_q <= 1'b0;
		end
	end

	// Write address channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			s_awready <= 1'b1;
		end else if (s_awvalid && s_awready) begin
			aw_have_q <= 1'b1;
			aw_addr_q <= s_awaddr;
			s_awready <= 1'b0;
		end else if (wr_fire) begin
			aw_have_q <= 1'b0;
			s_awready <= 1'b1;
		end
	end

	// Write data channel
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			s_wready <= 1'b1;
		end else if (s_wvalid && s_wready) begin
			w_have_q <= 1'b1;
			w_data_q <= s_wdata;
			w_strb_q <= s_wstrb;
			s_wready <= 1'b0;
		end else if (wr_fire) begin
			w_have_q <= 1'b0;
			s_wready <= 1'b1;
		end
	end

	// Write response; unmapped addresses answer SLVERR
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_bvalid <= 1'b0;
			s_bresp  <= resp_okay;
		end else if (wr_fire) begin
			s_bvalid <= 1'b1;
			s_bresp  <= (aw_addr_q > mptr_addr || aw_addr_q[1:0] != 2'h0)
				? resp_slverr : resp_okay;
		end else if (s_bready) begin
			s_bvalid <= 1'b0;
		end
	end

	// Read channel, one-cycle answer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_arready <= 1'b1;
			s_rvalid  <= 1'b0;
			s_rdata   <= 32'h0000_0000;
			s_rresp   <= resp_okay;
		end else if (s_arvalid && s_arready) begin
			s_arready <= 1'b0;
			s_rvalid  <= 1'b1;
			s_rresp   <= resp_okay;
			unique case (s_araddr)
				bank_ptr_addr:  s_rdata <= {29'h0, bank_q};
				status_addr:    s_rdata <= {24'h0, 2'b00, status_q[5:0]};
				pc_low_addr:    s_rdata <= {24'h0, pc_in[7:0]};
				tbl_lo_addr:    s_rdata <= {24'h0, tbl_lo_q};
				tbl_hi_addr:    s_rdata <= {24'h0, tbl_hi_q};
				tbl_latch_addr: s_rdata <= {24'h0, tbl_latch_q};
				clk_ctrl_addr:  s_rdata <= {24'h0, clk_ctrl_q[7:5],
					3'b000, clk_ctrl_q[1:0]};
				acc_addr:       s_rdata <= {24'h0, acc_q};
				indirect_addr:  s_rdata <= 32'h0000_0000;
				mptr_addr:      s_rdata <= {24'h0, mptr_q};
				default: begin
					s_rdata <= 32'h0000_0000;
					s_rresp <= resp_slverr;
				end
			endcase
		end else if (s_rvalid && s_rready) begin
			s_rvalid  <= 1'b0;
			s_arready <= 1'b1;
		end
	end

	// Bank pointer; the reset cause is only known after release
	// keep bank after watchdog-in-idle reset
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bank_q <= bank_rst;
		end else if (boot_q && wdt_idle_reset) begin
			bank_q <= bank_keep_q;
		end else if (wr_fire && wr_lane0 && aw_addr_q == bank_ptr_addr) begin
			bank_q <= wr_byte[bank_w-1:0];
		end
	end

	// Retention copy with no reset, frozen while reset is held
	always_ff @(posedge clk) begin
		if (rst_n) begin
			bank_keep_q <= bank_q;
		end
	end

	bank_decode u_bank_decode (
		.bank_sel    (bank_q),
		.via_any_ptr (dm_via_any_ptr),
		.addr        (dm_addr),
		.bank_out    (bank_res),
		.bank_valid  (bank_res_ok)
	);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dm_bank     <= bank_code_0;
			dm_bank_ok  <= 1'b1;
			dm_ptr_addr <= 8'h00;
		end else begin
			dm_bank     <= bank_res;
			dm_bank_ok  <= bank_res_ok;
			dm_ptr_addr <= dm_via_any_ptr ? mptr_q : dm_addr;
		end
	end

	assign alu_f = calc_flags(alu_ev.op, alu_ev.a, alu_ev.b, alu_ev.cin,
		alu_ev.result, alu_ev.rot_cout);

	// Arithmetic flags; ALU update wins over a software write
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			arith_q <= 4'h0;
		end else if (alu_ev.valid && alu_ev.op != op_none) begin
			if (alu_ev.op == op_add || alu_ev.op == op_sub) begin
				arith_q[status_c_bit]    <= alu_f.carry;
				arith_q[status_half_bit] <= alu_f.half_bit_flag;
				arith_q[status_flow_bit] <= alu_f.signed_flow_flag;
			end
			if (alu_ev.op == op_rot_c) begin
				arith_q[status_c_bit] <= alu_f.carry;
			end
			if (alu_ev.op != op_rot_c) begin
				arith_q[status_z_bit] <= alu_f.zero;
			end
		end else if (wr_fire && wr_lane0 && aw_addr_q == status_addr) begin
			arith_q <= wr_byte[3:0];
		end
	end

	// Halted and expired flags; software writes do not reach them
	// write-protected flags
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			halted_q  <= 1'b0;
			expired_q <= 1'b0;
		end else begin
			if (sys_ev.halt) begin
				halted_q <= 1'b1;
			end else if (sys_ev.wdt_clear) begin
				halted_q <= 1'b0;
			end
			if (sys_ev.wdt_expire) begin
				expired_q <= 1'b1;
			end else if (sys_ev.wdt_clear || sys_ev.halt) begin
				expired_q <= 1'b0;
			end
		end
	end

	// top two bits are not implemented
	assign status_q = {2'b00, expired_q, halted_q, arith_q};

	// no automatic status save exists anywhere in this block
	assign status_out = status_q;

	// Accumulator is the only path between user registers
	// move via accumulator
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= 8'h00;
		end else if (acc_load) begin
			acc_q <= acc_in;
		end else if (wr_fire && wr_lane0 && aw_addr_q == acc_addr) begin
			acc_q <= wr_byte;
		end
	end

	// Table pointers, memory pointer and clock control
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tbl_lo_q   <= 8'h00;
			tbl_hi_q   <= 8'h00;
			mptr_q     <= 8'h00;
			clk_ctrl_q <= clk_ctrl_rst;
		end else if (wr_fire && wr_lane0) begin
			unique case (aw_addr_q)
				tbl_lo_addr:   tbl_lo_q   <= wr_byte;
				tbl_hi_addr:   tbl_hi_q   <= wr_byte;
				mptr_addr:     mptr_q     <= wr_byte;
				clk_ctrl_addr: clk_ctrl_q <= wr_byte & 8'hE3;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_jump     <= 11'h000;
			pc_jump_vld <= 1'b0;
			dummy_cycle <= 1'b0;
		end else begin
			pc_jump_vld <= 1'b0;
			dummy_cycle <= pc_jump_vld;
			if (wr_fire && wr_lane0 && aw_addr_q == pc_low_addr) begin
				pc_jump     <= {pc_in[10:8], wr_byte};
				pc_jump_vld <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tbl_latch_q    <= 8'h00;
			tbl_low_byte   <= 8'h00;
			tbl_low_vld    <= 1'b0;
			tbl_fetch_addr <= 16'h0000;
		end else begin
			tbl_fetch_addr <= {tbl_hi_q, tbl_lo_q};
			tbl_low_vld    <= tbl_rd;
			if (tbl_rd) begin
				tbl_latch_q  <= prog_word[15:8];
				tbl_low_byte <= prog_word[7:0];
			end
		end
	end

	// Clock source select output
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sys_clk_sel  <= 3'h0;
			sys_clk_slow <= 1'b0;
		end else begin
			sys_clk_sel  <= clk_ctrl_q[clk_sel_lsb +: 3];
			sys_clk_slow <= (clk_ctrl_q[clk_sel_lsb +: 3] == clk_sel_slow);
		end
	end

endmodule : core_sfr

// ### rtl/core_sfr_pkg.sv
package core_sfr_pkg;

	// Register byte addresses on the AXI4-Lite slave
	localparam logic [7:0] bank_ptr_addr      = 8'h00;
	localparam logic [7:0] status_addr        = 8'h04;
	localparam logic [7:0] pc_low_addr        = 8'h08;
	localparam logic [7:0] tbl_lo_addr        = 8'h0C;
	localparam logic [7:0] tbl_hi_addr        = 8'h10;
	localparam logic [7:0] tbl_latch_addr     = 8'h14;
	localparam logic [7:0] clk_ctrl_addr      = 8'h18;
	localparam logic [7:0] acc_addr           = 8'h1C;
	localparam logic [7:0] indirect_addr      = 8'h20;
	localparam logic [7:0] mptr_addr          = 8'h24;

	// Field layout
	localparam int bank_w        = 3;
	localparam int status_expired_bit = 5;
	localparam int status_halted_bit  = 4;
	localparam int status_flow_bit    = 3;
	localparam int status_z_bit       = 2;
	localparam int status_half_bit    = 1;
	localparam int status_c_bit       = 0;
	localparam int clk_sel_lsb        = 5;

	// Reset values, slow clock select code and response codes
	localparam logic [2:0] bank_rst     = 3'h0;
	localparam logic [7:0] clk_ctrl_rst = 8'h00;
	localparam logic [2:0] clk_sel_slow = 3'h7;
	localparam logic [1:0] resp_okay    = 2'h0;
	localparam logic [1:0] resp_slverr  = 2'h2;

	// Bank codes
	localparam logic [2:0] bank_code_0 = 3'h0;
	localparam logic [2:0] bank_code_4 = 3'h4;
	localparam logic [2:0] bank_code_5 = 3'h5;

	// Oscillator rates in kHz
	localparam int fast_osc_khz = 12000;
	localparam int slow_osc_khz = 32;

	// ALU operation kinds
	typedef enum logic [2:0] {
		op_none, op_add, op_sub, op_logic, op_rot_c
	} alu_op_t;

	// ALU result carried to the flag logic
	typedef struct packed {
		logic    valid;
		alu_op_t op;
		logic [7:0] a;
		logic [7:0] b;
		logic    cin;
		logic [7:0] result;
		logic    rot_cout;
	} alu_ev_t;

	// Core system events, each a one-cycle strobe
	typedef struct packed {
		logic halt;
		logic wdt_clear;
		logic wdt_expire;
		logic idle_or_sleep;
	} sys_ev_t;

	typedef struct packed {
		logic carry;
		logic half_bit_flag;
		logic zero;
		logic signed_flow_flag;
	} arith_flags_t;

	// Arithmetic flag computation, used for add, sub, logic and rotate paths
	function automatic arith_flags_t calc_flags(alu_op_t op,
			logic [7:0] a, logic [7:0] b, logic cin, logic [7:0] r,
			logic rot_c);
		arith_flags_t f;
		logic [8:0] s;
		logic [4:0] n;
		logic [7:0] bb;
		logic [6:0] lo7;
		logic c7;
		f = '0;
		bb = (op == op_sub) ? ~b : b;
		s = {1'b0, a} + {1'b0, bb} + {8'h00, (op == op_sub) ? 1'b1 : cin};
		n = {1'b0, a[3:0]} + {1'b0, bb[3:0]} +
			{4'h0, (op == op_sub) ? 1'b1 : cin};
		lo7 = a[6:0] + bb[6:0] + {6'h00, (op == op_sub) ? 1'b1 : cin};
		c7 = lo7[6] ^ a[6] ^ bb[6];
		c7 = (a[6] & bb[6]) | ((a[6] ^ bb[6]) & c7);
		f.carry            = (op == op_rot_c) ? rot_c : s[8];
		f.half_bit_flag    = n[4];
		f.zero             = (r == 8'h00);
		f.signed_flow_flag = c7 ^ s[8];
		return f;
	endfunction : calc_flags

endpackage : core_sfr_pkg

// ### rtl/bank_decode.sv
`timescale 1ns/10ps
// Resolves a data-memory access to a physical bank
module bank_decode
	import core_sfr_pkg::*;
(
	// Access request
	input  wire logic [2:0] bank_sel,
	input  wire logic       via_any_ptr,
	input  wire logic [7:0] addr,
	// Resolution
	output logic [2:0]      bank_out,
	output logic            bank_valid
);

	// Direct accesses always land in bank 0; pointer accesses use the bank pointer
	always_comb begin
		bank_out   = bank_code_0;
		bank_valid = 1'b1;
		if (addr[7] == 1'b0 && !via_any_ptr) begin
			bank_out = bank_code_0;
		end else if (via_any_ptr) begin
			bank_out   = bank_sel;
			bank_valid = (bank_sel == bank_code_0) ||
				(bank_sel == bank_code_4) || (bank_sel == bank_code_5);
		end
	end

endmodule : bank_decode

// ### testbench/core_sfr_assertions.sv
`timescale 1ns/10ps
// Watches flags, jump, bank and clock outputs of the core block
module core_sfr_assertions
	import core_sfr_pkg::*;
(
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// Core side inputs
	input  wire alu_ev_t     alu_ev,
	input  wire sys_ev_t     sys_ev,
	input  wire logic [10:0] pc_in,
	input  wire logic        dm_via_any_ptr,
	// Observed outputs
	input  wire logic [10:0] pc_jump,
	input  wire logic        pc_jump_vld,
	input  wire logic        dummy_cycle,
	input  wire logic [2:0]  dm_bank,
	input  wire logic [2:0]  sys_clk_sel,
	input  wire logic        sys_clk_slow,
	input  wire logic [7:0]  status_out
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	// Any halt, clear or expire strobe; without one the two flags must hold
	logic ev;
	assign ev = sys_ev.halt | sys_ev.wdt_clear | sys_ev.wdt_expire;

	a_top_zero: assert property (status_out[7:6] == 2'b00)
		else $error("status top bits not zero");
	a_halt_sets: assert property (sys_ev.halt |=> status_out[4])
		else $error("halted flag not set");
	a_clr_pd: assert property (
		sys_ev.wdt_clear && !sys_ev.halt |=> !status_out[4])
		else $error("halted flag not cleared");
	a_expire_sets: assert property (
		sys_ev.wdt_expire |=> status_out[5])
		else $error("expired flag not set");
	a_to_clear: assert property (
		ev && !sys_ev.wdt_expire |=> !status_out[5])
		else $error("expired flag not cleared");
	a_flags_hold: assert property (
		!ev |=> $stable(status_out[5:4]))
		else $error("system flags moved without event");
	a_zero_flag: assert property (
		alu_ev.valid && alu_ev.op inside {op_add, op_sub}
		|=> status_out[2] == ($past(alu_ev.result) == 8'h00))
		else $error("zero flag wrong");
	a_pc_dummy: assert property (pc_jump_vld |=> dummy_cycle)
		else $error("no dummy cycle after jump");
	a_jump_page: assert property (
		pc_jump_vld |-> pc_jump[10:8] == pc_in[10:8])
		else $error("jump left current page");
	a_bank_direct: assert property (
		!dm_via_any_ptr |=> dm_bank == 3'h0)
		else $error("direct access not in bank zero");
	a_clk_slow: assert property (
		sys_clk_slow == (sys_clk_sel == clk_sel_slow))
		else $error("slow clock flag disagrees with select");
endmodule : core_sfr_assertions

// ### testbench/cpu_model.sv
`timescale 1ns/10ps
// Stand-in for the instruction decoder and ALU
module cpu_model
	import core_sfr_pkg::*;
(
	// Clock
	input  wire logic clk,
	// Events toward the flag logic
	output alu_ev_t   alu_ev,
	output sys_ev_t   sys_ev
);
	// Idle until a scenario asks for an event
	initial begin
		alu_ev = '0;
		sys_ev = '0;
	end

	task automatic alu(input alu_op_t op, input logic [7:0] a, b, r,
			input logic rc);
		@(posedge clk);
		alu_ev <= '{1'b1, op, a, b, 1'b0, r, rc};
		@(posedge clk);
		alu_ev <= '0;
	endtask : alu

	task automatic sys(input logic h, c, e);
		@(posedge clk);
		sys_ev <= '{h, c, e, 1'b0};
		@(posedge clk);
		sys_ev <= '0;
	endtask : sys
endmodule : cpu_model

// ### testbench/core_status_and_bank_select_test.sv
`timescale 1ns/10ps
module core_status_and_bank_select_test;
	import core_sfr_pkg::*;
	// Clock, reset and bus master drives
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  s_awaddr = '0, s_araddr = '0;
	logic [31:0] s_wdata = '0;
	logic [3:0]  s_wstrb = '0;
	logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
	logic        s_arvalid = 1'b0, s_rready = 1'b0;
	// Core side drives
	logic        tbl_rd = 1'b0, dm_via = 1'b0;
	logic        wdt_idle = 1'b0, acc_ld = 1'b0;
	logic [7:0]  acc_di = '0;
	logic [10:0] pc_in = 11'h5AB;
	logic [15:0] prog_word = '0;
	// Design outputs
	logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic        pc_jump_vld, dummy_cycle, tbl_low_vld, sys_clk_slow;
	logic        dm_bank_ok;
	logic [7:0]  dm_ptr_addr;
	logic [1:0]  s_bresp, s_rresp;
	logic [31:0] s_rdata;
	logic [10:0] pc_jump, jmp_q = '0;
	logic [15:0] tbl_fetch_addr;
	logic [7:0]  tbl_low_byte, status_out;
	logic [2:0]  dm_bank, sys_clk_sel;
	alu_ev_t     alu_ev;
	sys_ev_t     sys_ev;
	int          errors = 0, cmp_count = 0;

	core_sfr dut_u (.clk, .rst_n, .wdt_idle_reset(wdt_idle), .s_awaddr,
		.s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready,
		.s_bresp, .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready,
		.s_rdata, .s_rresp, .s_rvalid, .s_rready, .alu_ev, .sys_ev,
		.acc_load(acc_ld), .acc_in(acc_di), .pc_in, .tbl_rd, .prog_word,
		.pc_jump, .pc_jump_vld, .dummy_cycle, .tbl_fetch_addr,
		.tbl_low_byte, .tbl_low_vld, .dm_via_any_ptr(dm_via),
		.dm_addr(8'h10), .dm_bank, .dm_bank_ok, .dm_ptr_addr,
		.sys_clk_sel, .sys_clk_slow, .status_out);
	cpu_model cpu_u (.clk, .alu_ev, .sys_ev);

	always #2 clk = ~clk;
	// Jump valid strobe lives one cycle only, so keep the target
	always @(posedge clk) if (pc_jump_vld) jmp_q <= pc_jump;

	task automatic chk(input logic [31:0] g, e);
		cmp_count++;
		if (g !== e) begin
			errors++;
			$display("MISMATCH %0t got %h exp %h", $time, g, e);
		end
	endtask : chk
	// Write on lane 0; each channel released when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		s_awaddr  <= a;
		s_wdata   <= d;
		s_wstrb   <= 4'h1;
		s_awvalid <= 1'b1;
		s_wvalid  <= 1'b1;
		s_bready  <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid && n < 99);
		s_bready <= 1'b0;
		if (n == 99) chk(32'(s_bvalid), 32'h1);
		chk(32'(s_bresp), 32'(resp_okay));
	endtask : wr
	// Read; data compare skipped where the value is unspecified
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
			input logic [1:0] er = resp_okay, input bit cd = 1'b1);
		int n = 0;
		@(posedge clk);
		s_araddr  <= a;
		s_arvalid <= 1'b1;
		s_rready  <= 1'b1;
		do begin
			@(posedge clk);
			n++;
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid && n < 99);
		s_rready <= 1'b0;
		if (n == 99) chk(32'(s_rvalid), 32'h1);
		if (cd) chk(s_rdata, ed);
		chk(32'(s_rresp), 32'(er));
	endtask : rd

	task automatic t_reset;
		rd(bank_ptr_addr, 32'h0);
		rd(status_addr, 32'h0);
		rd(clk_ctrl_addr, 32'(clk_ctrl_rst));
	endtask : t_reset
	task automatic t_bank;
		logic [2:0] c [3] = '{bank_code_5, bank_code_4, bank_code_0};
		wr(mptr_addr, 32'h9C);
		foreach (c[i]) begin
			wr(bank_ptr_addr, {29'h1FFFFFFF, c[i]});
			rd(bank_ptr_addr, 32'(c[i]));
			dm_via <= 1'b1;
			@(posedge clk);
			#1 chk(32'({dm_bank_ok, dm_bank, dm_ptr_addr}),
				32'({1'b1, c[i], 8'h9C}));
			@(posedge clk);
			dm_via <= 1'b0;
			@(posedge clk);
			#1 chk(32'({dm_bank_ok, dm_bank, dm_ptr_addr}),
				32'({1'b1, bank_code_0, 8'h10}));
		end
	endtask : t_bank
	task automatic t_status;
		cpu_u.sys(1'b1, 1'b0, 1'b0);
		#1 chk(32'(status_out), 32'h10);
		cpu_u.sys(1'b0, 1'b0, 1'b1);
		#1 chk(32'(status_out), 32'h30);
		wr(status_addr, 32'hFF);
		rd(status_addr, 32'h3F);
		cpu_u.sys(1'b1, 1'b0, 1'b0);
		#1 chk(32'(status_out), 32'h1F);
		cpu_u.sys(1'b0, 1'b1, 1'b0);
		#1 chk(32'(status_out), 32'h0F);
	endtask : t_status
	// Flag nibble is {overflow, zero, half carry, carry}
	task automatic t_alu;
		alu_op_t    op [4] = '{op_add, op_add, op_sub, op_sub};
		logic [7:0] a [4] = '{8'hFF, 8'h7F, 8'h05, 8'h03};
		logic [7:0] b [4] = '{8'h01, 8'h01, 8'h03, 8'h05};
		logic [7:0] r [4] = '{8'h00, 8'h80, 8'h02, 8'hFE};
		logic [3:0] f [4] = '{4'h7, 4'hA, 4'h3, 4'h0};
		foreach (op[i]) begin
			cpu_u.alu(op[i], a[i], b[i], r[i], 1'b0);
			#1 chk(32'(status_out[3:0]), 32'(f[i]));
		end
		cpu_u.alu(op_rot_c, 8'h80, 8'h00, 8'h00, 1'b1);
		#1 chk(32'(status_out[0]), 32'h1);
	endtask : t_alu
	task automatic t_jump_table;
		wr(pc_low_addr, 32'h34);
		repeat (3) @(posedge clk);
		chk(32'(jmp_q), 32'h534);
		wr(tbl_lo_addr, 32'h12);
		wr(tbl_hi_addr, 32'h03);
		@(posedge clk);
		#1 chk(32'(tbl_fetch_addr), 32'h0312);
		@(posedge clk);
		prog_word <= 16'hABCD;
		tbl_rd    <= 1'b1;
		@(posedge clk);
		tbl_rd <= 1'b0;
		#1 chk(32'({tbl_low_vld, tbl_low_byte}), 32'h1CD);
		rd(tbl_latch_addr, 32'hAB);
	endtask : t_jump_table
	task automatic t_misc;
		acc_ld <= 1'b1;
		acc_di <= 8'h5A;
		@(posedge clk);
		acc_ld <= 1'b0;
		rd(acc_addr, 32'h5A);
		wr(indirect_addr, 32'hFF);
		rd(indirect_addr, 32'h0);
		rd(8'h40, 32'h0, resp_slverr, 1'b0);
		wr(clk_ctrl_addr, 32'hE0);
		@(posedge clk);
		#1 chk(32'({sys_clk_slow, sys_clk_sel}), 32'hF);
		wr(clk_ctrl_addr, 32'h20);
		@(posedge clk);
		#1 chk(32'({sys_clk_slow, sys_clk_sel}), 32'h1);
	endtask : t_misc
	// Second reset in mid-run
	task automatic t_rst2;
		wr(bank_ptr_addr, 32'h5);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		rd(bank_ptr_addr, 32'h0);
		rd(status_addr, 32'h0);
		// Watchdog reset from idle keeps the bank
		wr(bank_ptr_addr, 32'h5);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n    <= 1'b1;
		wdt_idle <= 1'b1;
		@(posedge clk);
		wdt_idle <= 1'b0;
		rd(bank_ptr_addr, 32'h5);
	endtask : t_rst2

	task automatic wrap_up;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : wrap_up

	// Main sequence
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		t_reset();
		t_bank();
		t_status();
		t_alu();
		t_jump_table();
		t_misc();
		t_rst2();
		wrap_up();
	end
	// Run needs about 140 cycles; cut a hang well beyond
	initial begin
		#40000;
		errors++;
		wrap_up();
	end
endmodule : core_status_and_bank_select_test

bind core_sfr core_sfr_assertions chk_u (.clk, .rst_n, .alu_ev, .sys_ev,
	.pc_in, .dm_via_any_ptr, .pc_jump, .pc_jump_vld, .dummy_cycle,
	.dm_bank, .sys_clk_sel, .sys_clk_slow, .status_out);
